// File: rtl/sscmd_regs.svh
// register indices, characters, bit fields and timing counts
`ifndef SSCMD_REGS_SVH
`define SSCMD_REGS_SVH
`define SSC_CLK_PERIOD_NS   100
`define SSC_SERVO_PERIOD_NS 120000
`define SSC_SERVO_CYC       (`SSC_SERVO_PERIOD_NS / `SSC_CLK_PERIOD_NS)
`define SSC_CMD_WRITE       32'h0000000B
`define SSC_CMD_READ        32'h0000000C
`define SSC_REG_POS         4'h1
`define SSC_REG_DELAY       4'h5
`define SSC_REG_ACCUM       4'hA
`define SSC_REG_MODE        4'hB
`define SSC_REG_CMD_VEL     4'hC
`define SSC_REG_ACCEL       4'hD
`define SSC_REG_SAVE        4'hF
`define SSC_MODE_FOLLOW     0
`define SSC_MODE_REVERSE    1
`define SSC_RST_MODE        32'h00000000
`define SSC_RST_CMD_VEL     32'h00000000
`define SSC_RST_ACCEL       32'h00000100
`define SSC_RST_ADDR        8'h10
`define SSC_CH_AT           8'h40
`define SSC_CH_SP           8'h20
`define SSC_CH_CR           8'h0D
`define SSC_CH_0            8'h30
`define SSC_CH_9            8'h39
`define SSC_CH_A            8'h41
`define SSC_CH_ACK          8'h2A
`define SSC_CH_DATA         8'h23
`define SSC_CH_ERR          8'h21
`define SSC_VEL_SHIFT       16
`endif

// File: rtl/sscmd_pkg.sv
// types shared by the command interpreter
package sscmd_pkg;
  typedef enum logic [1:0] {
    SSCMD_HUNT,
    SSCMD_FIELD,
    SSCMD_EXEC,
    SSCMD_REPLY
  } sscmd_state_t;
  typedef enum logic [1:0] {
    SSCMD_ACK,
    SSCMD_DATA,
    SSCMD_ERR
  } sscmd_reply_t;
endpackage

// File: rtl/sscmd_fifo.sv
// reply byte fifo with valid and ready on both sides
`timescale 1ns/1ps
module sscmd_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem_reg [D];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0]   cnt_reg;
  wire           push = in_valid && in_ready;
  wire           pop  = out_valid && out_ready;

  assign in_ready  = (cnt_reg != (AW+1)'(D));
  assign out_valid = (cnt_reg != '0);
  assign out_data  = mem_reg[rd_reg];

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      if (push)
        wr_reg <= (wr_reg == AW'(D-1)) ? '0 : wr_reg + AW'(1);
      if (pop)
        rd_reg <= (rd_reg == AW'(D-1)) ? '0 : rd_reg + AW'(1);
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge clk)
  begin
    if (push)
      mem_reg[wr_reg] <= in_data;
  end
endmodule

// File: rtl/sscmd_top.sv
// serial command interpreter and trajectory front end
`timescale 1ns/1ps
`include "sscmd_regs.svh"
module sscmd_top #(
  parameter int FIFO_DEPTH = 8,
  parameter int SERVO_CYC  = `SSC_SERVO_CYC
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  unit_addr,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_valid,
  output logic             rx_ready,
  output logic [7:0]       tx_data,
  output logic             tx_valid,
  input  wire logic        tx_ready,
  input  wire logic [31:0] enc_count,
  input  wire logic [31:0] act_pos,
  input  wire logic [31:0] act_vel,
  input  wire logic [31:0] act_acc,
  output logic             servo_tick,
  output logic [31:0]      tgt_pos,
  output logic [31:0]      tgt_vel,
  output logic [31:0]      tgt_acc,
  output logic [31:0]      torque,
  output logic             reboot
);
  localparam logic [11:0] TICK_LAST = 12'(SERVO_CYC - 1);

  function automatic logic [31:0] dec_acc(input logic [31:0] a,
                                          input logic [7:0]  c);
    dec_acc = 32'(a * 32'h0000000A) + {28'h0, c[3:0]};
  endfunction

  function automatic logic [7:0] hex_ch(input logic [3:0] n);
    hex_ch = (n < 4'hA) ? (`SSC_CH_0 + {4'h0, n})
                        : (`SSC_CH_A + {4'h0, n} - 8'h0A);
  endfunction

  function automatic logic [31:0] flip(input logic [31:0] v,
                                       input logic        rev);
    flip = rev ? (32'h0 - v) : v;
  endfunction

  sscmd_pkg::sscmd_state_t state_reg;
  sscmd_pkg::sscmd_reply_t kind_reg;
  logic [31:0] acc_reg;
  logic [31:0] f_addr_reg;
  logic [31:0] f_cmd_reg;
  logic [31:0] f_p1_reg;
  logic [2:0]  fidx_reg;
  logic        digit_reg;
  logic [3:0]  bidx_reg;
  logic [31:0] rdata_reg;
  logic [31:0] regs_reg [16];
  logic [31:0] save_mode_reg;
  logic [31:0] save_vel_reg;
  logic [31:0] save_acc_reg;
  logic [11:0] tick_cnt_reg;
  logic [31:0] pos_reg;
  logic [31:0] vel_reg;
  logic [31:0] acc_out_reg;
  logic [31:0] enc_prev_reg;

  // host side byte decoding
  wire        rx_take   = rx_valid && rx_ready;
  wire        is_digit  = (rx_data >= `SSC_CH_0) && (rx_data <= `SSC_CH_9);
  wire        is_at     = (rx_data == `SSC_CH_AT);
  wire        is_sp     = (rx_data == `SSC_CH_SP);
  wire        is_cr     = (rx_data == `SSC_CH_CR);
  wire [31:0] acc_next  = dec_acc(acc_reg, rx_data);
  wire [3:0]  ridx      = f_p1_reg[3:0];
  wire        idx_ok    = (f_p1_reg[31:4] == 28'h0);
  wire        addr_hit  = (f_addr_reg == {24'h0, unit_addr});
  // command code and field count tell a read (three fields) from a write (four)
  wire        do_write  = (f_cmd_reg == `SSC_CMD_WRITE) && (fidx_reg == 3'h4)
                          && idx_ok && (ridx != `SSC_REG_POS);
  wire        do_read   = (f_cmd_reg == `SSC_CMD_READ) && (fidx_reg == 3'h3)
                          && idx_ok;
  wire        exec_wr   = (state_reg == sscmd_pkg::SSCMD_EXEC) && addr_hit
                          && do_write;

  // reply byte selection
  logic [7:0] rbyte;
  wire  [3:0] last_idx  = (kind_reg == sscmd_pkg::SSCMD_DATA) ? 4'h9 : 4'h1;
  wire  [3:0] nib_sel   = 4'h8 - bidx_reg;
  wire  [3:0] nib       = 4'(rdata_reg >> {nib_sel[2:0], 2'b00});
  wire        fifo_rdy;
  wire        push      = (state_reg == sscmd_pkg::SSCMD_REPLY);
  wire        push_done = push && fifo_rdy && (bidx_reg == last_idx);

  always_comb
  begin
    rbyte = `SSC_CH_CR;
    if (bidx_reg == 4'h0)
    begin
      case (kind_reg)
        sscmd_pkg::SSCMD_ACK:  rbyte = `SSC_CH_ACK;
        sscmd_pkg::SSCMD_DATA: rbyte = `SSC_CH_DATA;
        default:               rbyte = `SSC_CH_ERR;
      endcase
    end
    else if (bidx_reg != last_idx)
      rbyte = hex_ch(nib);
  end

  assign rx_ready = (state_reg == sscmd_pkg::SSCMD_HUNT)
                 || (state_reg == sscmd_pkg::SSCMD_FIELD);

  // parser and reply sequencer
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      state_reg  <= sscmd_pkg::SSCMD_HUNT;
      kind_reg   <= sscmd_pkg::SSCMD_ACK;
      acc_reg    <= '0;
      f_addr_reg <= '0;
      f_cmd_reg  <= '0;
      f_p1_reg   <= '0;
      fidx_reg   <= '0;
      digit_reg  <= 1'b0;
      bidx_reg   <= '0;
      rdata_reg  <= '0;
    end
    else
    begin
      case (state_reg)
        sscmd_pkg::SSCMD_HUNT:
        begin
          if (rx_take && is_at)
          begin
            state_reg <= sscmd_pkg::SSCMD_FIELD;
            acc_reg   <= '0;
            fidx_reg  <= '0;
            digit_reg <= 1'b0;
          end
        end
        sscmd_pkg::SSCMD_FIELD:
        begin
          if (rx_take)
          begin
            if (is_digit)
            begin
              acc_reg   <= acc_next;
              digit_reg <= 1'b1;
            end
            else if ((is_sp || is_cr) && digit_reg)
            begin
              case (fidx_reg)
                3'h0:    f_addr_reg <= acc_reg;
                3'h1:    f_cmd_reg  <= acc_reg;
                3'h2:    f_p1_reg   <= acc_reg;
                3'h3:    rdata_reg  <= acc_reg;
                default: ;
              endcase
              acc_reg   <= '0;
              digit_reg <= 1'b0;
              // saturate so surplus fields stay an error
              if (fidx_reg != 3'h7)
                fidx_reg <= fidx_reg + 3'h1;
              if (is_cr)
                state_reg <= sscmd_pkg::SSCMD_EXEC;
            end
            else if (is_at)
            begin
              acc_reg   <= '0;
              fidx_reg  <= '0;
              digit_reg <= 1'b0;
            end
            else
              state_reg <= sscmd_pkg::SSCMD_HUNT;
          end
        end
        sscmd_pkg::SSCMD_EXEC:
        begin
          bidx_reg <= '0;
          if (!addr_hit)
            state_reg <= sscmd_pkg::SSCMD_HUNT;
          else
          begin
            state_reg <= sscmd_pkg::SSCMD_REPLY;
            if (do_read)
            begin
              kind_reg  <= sscmd_pkg::SSCMD_DATA;
              rdata_reg <= (ridx == `SSC_REG_POS) ? act_pos : regs_reg[ridx];
            end
            else if (do_write)
              kind_reg <= sscmd_pkg::SSCMD_ACK;
            else
              kind_reg <= sscmd_pkg::SSCMD_ERR;
          end
        end
        sscmd_pkg::SSCMD_REPLY:
        begin
          if (fifo_rdy)
            bidx_reg <= bidx_reg + 4'h1;
          if (push_done)
            state_reg <= sscmd_pkg::SSCMD_HUNT;
        end
        default: state_reg <= sscmd_pkg::SSCMD_HUNT;
      endcase
    end
  end

  sscmd_fifo #(
    .W (8),
    .D (FIFO_DEPTH)
  ) u_tx_fifo (
    .clk       (ref_clk),
    .rst_n     (rst_n),
    .in_data   (rbyte),
    .in_valid  (push),
    .in_ready  (fifo_rdy),
    .out_data  (tx_data),
    .out_valid (tx_valid),
    .out_ready (tx_ready)
  );

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || servo_tick)
      tick_cnt_reg <= '0;
    else
      tick_cnt_reg <= tick_cnt_reg + 12'h1;
  end
  assign servo_tick = (tick_cnt_reg == TICK_LAST);

  wire save_hit = exec_wr && (ridx == `SSC_REG_SAVE);

  // register file, delay count and saved parameters
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 16; i++)
        regs_reg[i] <= '0;
      regs_reg[`SSC_REG_MODE]    <= `SSC_RST_MODE;
      regs_reg[`SSC_REG_CMD_VEL] <= `SSC_RST_CMD_VEL;
      regs_reg[`SSC_REG_ACCEL]   <= `SSC_RST_ACCEL;
      save_mode_reg <= `SSC_RST_MODE;
      save_vel_reg  <= `SSC_RST_CMD_VEL;
      save_acc_reg  <= `SSC_RST_ACCEL;
      reboot        <= 1'b0;
    end
    else
    begin
      reboot <= save_hit;
      if (reboot)
      begin
        regs_reg[`SSC_REG_MODE]    <= save_mode_reg;
        regs_reg[`SSC_REG_CMD_VEL] <= save_vel_reg;
        regs_reg[`SSC_REG_ACCEL]   <= save_acc_reg;
      end
      else if (save_hit)
      begin
        save_mode_reg <= regs_reg[`SSC_REG_MODE];
        save_vel_reg  <= regs_reg[`SSC_REG_CMD_VEL];
        save_acc_reg  <= regs_reg[`SSC_REG_ACCEL];
      end
      else if (exec_wr)
        regs_reg[ridx] <= rdata_reg;
      if (servo_tick && (regs_reg[`SSC_REG_DELAY] != 32'h0)
          && !(exec_wr && (ridx == `SSC_REG_DELAY)))
        regs_reg[`SSC_REG_DELAY] <= regs_reg[`SSC_REG_DELAY] - 32'h1;
    end
  end

  wire        follow   = regs_reg[`SSC_REG_MODE][`SSC_MODE_FOLLOW];
  wire        reverse  = regs_reg[`SSC_REG_MODE][`SSC_MODE_REVERSE];
  wire [31:0] cmd_vel  = regs_reg[`SSC_REG_CMD_VEL];
  wire [31:0] step     = regs_reg[`SSC_REG_ACCEL];
  wire [31:0] vel_diff = cmd_vel - vel_reg;
  wire        vel_up   = !vel_diff[31];
  wire [31:0] vel_gap  = vel_up ? vel_diff : (32'h0 - vel_diff);
  wire [31:0] vel_step = (vel_gap < step) ? vel_gap : step;
  wire [31:0] ctl_vel  = vel_up ? (vel_reg + vel_step) : (vel_reg - vel_step);
  wire [31:0] ctl_acc  = vel_up ? vel_step : (32'h0 - vel_step);
  wire [31:0] enc_dv   = enc_count - enc_prev_reg;

  // trajectory point per servo cycle
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || reboot)
    begin
      pos_reg      <= '0;
      vel_reg      <= '0;
      acc_out_reg  <= '0;
      enc_prev_reg <= '0;
    end
    else if (servo_tick)
    begin
      enc_prev_reg <= enc_count;
      if (follow)
      begin
        pos_reg     <= enc_count;
        vel_reg     <= enc_dv;
        acc_out_reg <= enc_dv - vel_reg;
      end
      else
      begin
        vel_reg     <= ctl_vel;
        acc_out_reg <= ctl_acc;
        pos_reg     <= pos_reg + 32'($signed(ctl_vel) >>> `SSC_VEL_SHIFT);
      end
    end
  end

  assign tgt_pos = flip(pos_reg, reverse);
  assign tgt_vel = flip(vel_reg, reverse);
  assign tgt_acc = flip(acc_out_reg, reverse);

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      torque <= '0;
    else
      torque <= (tgt_pos - act_pos) + (tgt_vel - act_vel)
              + (tgt_acc - act_acc);
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_ack_head;
    push && fifo_rdy && (bidx_reg == 4'h0) && (kind_reg == sscmd_pkg::SSCMD_ACK);
  endsequence
  sequence s_ack_tail;
    push && (rbyte == `SSC_CH_CR);
  endsequence

  AST_TX_ONLY_REPLY: assert property (
    push |-> addr_hit) else $error("reply without addressed packet");
  AST_OPEN_AT: assert property (
    (state_reg == sscmd_pkg::SSCMD_HUNT) && rx_take && !is_at
    |=> state_reg == sscmd_pkg::SSCMD_HUNT) else $error("packet without at");
  AST_MARKER: assert property (
    push && (bidx_reg == 4'h0) |-> (rbyte == `SSC_CH_ACK)
    || (rbyte == `SSC_CH_DATA) || (rbyte == `SSC_CH_ERR))
    else $error("bad reply marker");
  AST_READ_POS: assert property (
    (state_reg == sscmd_pkg::SSCMD_EXEC) && addr_hit && do_read
    && (ridx == `SSC_REG_POS) |=> rdata_reg == $past(act_pos))
    else $error("read of position wrong");
  AST_WRITE: assert property (
    exec_wr && (ridx != `SSC_REG_SAVE) && (ridx != `SSC_REG_DELAY)
    |=> regs_reg[$past(ridx)] == $past(rdata_reg))
    else $error("write not stored");
  AST_ACK_SEQ: assert property (
    s_ack_head |=> s_ack_tail) else $error("ack not closed by cr");
  AST_TICK_PERIOD: assert property (
    servo_tick |=> !servo_tick [*8]) else $error("servo tick too often");
  AST_DELAY_DEC: assert property (
    servo_tick && (regs_reg[`SSC_REG_DELAY] != 32'h0) && !exec_wr
    |=> regs_reg[`SSC_REG_DELAY] == $past(regs_reg[`SSC_REG_DELAY]) - 32'h1)
    else $error("delay count not decremented");
  AST_HOLD_POINT: assert property (
    !servo_tick && !reboot |=> $stable(pos_reg) && $stable(vel_reg))
    else $error("target changed between ticks");
  AST_REVERSE: assert property (
    reverse |-> tgt_vel == 32'h0 - vel_reg) else $error("direction ignored");
  AST_FOLLOW: assert property (
    servo_tick && follow && !reboot |=> pos_reg == $past(enc_count))
    else $error("follow position wrong");
  AST_REBOOT: assert property (
    reboot |=> regs_reg[`SSC_REG_MODE] == $past(save_mode_reg))
    else $error("saved mode not reloaded");
endmodule

// File: tb/sscmd_host.sv
// serial host model: sends packets, collects reply bytes
`timescale 1ns/1ps
module sscmd_host (
  input  wire logic       ref_clk,
  output logic [7:0]      rx_data,
  output logic            rx_valid,
  input  wire logic       rx_ready,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  input  wire logic       stall
);
  logic [7:0] got[$];
  initial
  begin
    rx_data  = 8'h00;
    rx_valid = 1'b0;
  end
  // sink takes no bytes while stalled
  always @(negedge ref_clk)
  begin
    tx_ready <= !stall;
  end
  always @(posedge ref_clk)
  begin
    if (tx_valid && tx_ready)
      got.push_back(tx_data);
  end
  task automatic send(input string s);
    int i;
    for (i = 0; i <= s.len(); i++)
    begin
      @(negedge ref_clk);
      rx_data  = (i == s.len()) ? 8'h0D : s[i];
      rx_valid = 1'b1;
      @(posedge ref_clk);
      while (!rx_ready)
        @(posedge ref_clk);
    end
    @(negedge ref_clk);
    rx_valid = 1'b0;
    rx_data  = ~rx_data;
  endtask
endmodule

// File: tb/sscmd_top_tb_top.sv
// self-checking bench for the command interpreter
`timescale 1ns/1ps
module sscmd_top_tb_top;
  localparam int SERVO_CYC = 200;
  typedef struct { string cmd; string rsp; } sscmd_row_t;
  logic        ref_clk;
  logic        rst_n;
  logic        stall;
  logic [7:0]  unit_addr;
  logic [7:0]  rx_data;
  logic        rx_valid;
  logic        rx_ready;
  logic [7:0]  tx_data;
  logic        tx_valid;
  logic        tx_ready;
  logic [31:0] enc_count;
  logic [31:0] act_pos;
  logic [31:0] act_vel;
  logic [31:0] act_acc;
  logic        servo_tick;
  logic [31:0] tgt_pos;
  logic [31:0] tgt_vel;
  logic [31:0] tgt_acc;
  logic [31:0] torque;
  logic        reboot;
  int          miscompares;
  int          comparisons;
  int          cycles;
  int          reboots;
  int          k;
  int          n;
  int          c;
  sscmd_row_t  rows[10] = '{
    '{"@16 11 10 50", "*"}, '{"@16 12 10", "#00000032"},
    '{"@16 12 1", "#12AB34CD"}, '{"@16 11 10 4294967295", "*"},
    '{"@16 12 10", "#FFFFFFFF"}, '{"@16 13 1", "!"},
    '{"@16 12 16", "!"}, '{"@16 11 1 5", "!"}, '{"@16 12 1 2", "!"},
    '{"@99 1@16 12 10", "#FFFFFFFF"}};

  sscmd_top #(.FIFO_DEPTH(8), .SERVO_CYC(SERVO_CYC)) sscmd_top_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .unit_addr(unit_addr),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .enc_count(enc_count), .act_pos(act_pos), .act_vel(act_vel),
    .act_acc(act_acc), .servo_tick(servo_tick), .tgt_pos(tgt_pos),
    .tgt_vel(tgt_vel), .tgt_acc(tgt_acc), .torque(torque),
    .reboot(reboot));

  sscmd_host sscmd_host_i (
    .ref_clk(ref_clk), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .stall(stall));

  always #50 ref_clk = ~ref_clk;

  task automatic test_done();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // cycle ceiling and pulse counting, sampled mid-cycle
  always @(negedge ref_clk)
  begin
    cycles++;
    if (reboot === 1'b1)
      reboots++;
    if (cycles == 30000)
    begin
      miscompares++;
      test_done();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic expect_reply(input string r);
    string e;
    int    i;
    int    w;
    e = {r, "\015"};
    w = 0;
    while (sscmd_host_i.got.size() < e.len() && w < 2000)
    begin
      @(posedge ref_clk);
      w++;
    end
    for (i = 0; i < e.len(); i++)
      chk("reply byte", {24'h000000, e[i]},
          (i < sscmd_host_i.got.size()) ? {24'h000000,
          sscmd_host_i.got[i]} : 32'hXXXXXXXX);
    sscmd_host_i.got.delete();
  endtask

  task automatic no_reply();
    repeat (40) @(posedge ref_clk);
    chk("silent tx", 32'h0, 32'(sscmd_host_i.got.size()));
  endtask

  task automatic wait_tick(output int cnt);
    cnt = 1;
    @(posedge ref_clk);
    while (servo_tick !== 1'b1 && cnt < 3 * SERVO_CYC)
    begin
      @(posedge ref_clk);
      cnt++;
    end
  endtask

  task automatic settle();
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  initial
  begin
    ref_clk     = 1'b0;
    rst_n       = 1'b0;
    stall       = 1'b0;
    unit_addr   = 8'h10;
    enc_count   = 32'h00000000;
    act_pos     = 32'h12AB34CD;
    act_vel     = 32'h00000010;
    act_acc     = 32'h00000003;
    miscompares = 0;
    comparisons = 0;
    cycles      = 0;
    reboots     = 0;
    repeat (5) @(negedge ref_clk);
    chk("tx_valid", 32'h0, {31'h0, tx_valid});
    chk("rx_ready", 32'h1, {31'h0, rx_ready});
    chk("torque", 32'h0, torque);
    chk("tgt_pos", 32'h0, tgt_pos);
    chk("reboot", 32'h0, {31'h0, reboot});
    rst_n = 1'b1;
    for (k = 0; k < 10; k++)
    begin
      sscmd_host_i.send(rows[k].cmd);
      expect_reply(rows[k].rsp);
    end
    sscmd_host_i.send("x@17 12 1");
    no_reply();
    sscmd_host_i.send("@16 1x 1");
    no_reply();
    wait_tick(n);
    wait_tick(n);
    chk("tick period", SERVO_CYC, n);
    sscmd_host_i.send("@16 11 5 100");
    expect_reply("*");
    sscmd_host_i.send("@16 12 5");
    expect_reply("#00000064");
    repeat (3) wait_tick(n);
    sscmd_host_i.send("@16 12 5");
    expect_reply("#00000061");
    @(negedge ref_clk);
    enc_count = 32'h00001234;
    sscmd_host_i.send("@16 11 11 1");
    expect_reply("*");
    repeat (3) wait_tick(n);
    settle();
    chk("tgt_pos", 32'h00001234, tgt_pos);
    chk("tgt_vel", 32'h0, tgt_vel);
    chk("tgt_acc", 32'h0, tgt_acc);
    chk("torque", 32'h1234 - act_pos - act_vel - act_acc, torque);
    sscmd_host_i.send("@16 11 11 3");
    expect_reply("*");
    wait_tick(n);
    settle();
    chk("tgt_pos", 32'h0 - 32'h00001234, tgt_pos);
    chk("torque", 32'h0 - 32'h1234 - act_pos - act_vel - act_acc,
        torque);
    wait_tick(n);
    c = reboots;
    sscmd_host_i.send("@16 11 11 0");
    expect_reply("*");
    sscmd_host_i.send("@16 11 12 512");
    expect_reply("*");
    sscmd_host_i.send("@16 11 15 0");
    expect_reply("*");
    chk("reboot pulses", 32'h1, 32'(reboots - c));
    wait_tick(n);
    settle();
    chk("tgt_vel", 32'h00000100, tgt_vel);
    chk("tgt_acc", 32'h00000100, tgt_acc);
    wait_tick(n);
    settle();
    chk("tgt_vel", 32'h00000200, tgt_vel);
    stall = 1'b1;
    sscmd_host_i.send("@16 12 1");
    repeat (30) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("rx_ready", 32'h0, {31'h0, rx_ready});
    chk("tx_valid", 32'h1, {31'h0, tx_valid});
    stall = 1'b0;
    expect_reply("#12AB34CD");
    test_done();
  end
endmodule
